//--- sfp_defs.vh
// Constants shared by the flash protection and pause logic.
// Assumes inclusion by bare name from each design file.
`ifndef SFP_DEFS_VH
`define SFP_DEFS_VH

// Command codes, used as module parameter defaults.
`define SFP_OP_WRITE_ENABLE_COMMAND_DEF 8'h06
`define SFP_OP_WRITE_DISABLE_COMMAND_DEF 8'h04
`define SFP_OP_WRR_DEF 8'h01
`define SFP_OP_RDSR_DEF 8'h05
`define SFP_OP_RDCR_DEF 8'h35
`define SFP_OP_PP_DEF 8'h02
`define SFP_OP_QPP_DEF 8'h32
`define SFP_OP_SE_DEF 8'hD8
`define SFP_OP_BE_DEF 8'hC7
`define SFP_OP_P4E_DEF 8'h20
`define SFP_OP_P8E_DEF 8'h40
`define SFP_OP_ONE_TIME_AREA_PROGRAM_DEF 8'h42

// Configuration register bit positions.
`define SFP_CFG_ORIGIN 5
`define SFP_CFG_VOLATILE 3
`define SFP_CFG_PARAM_TOP 2
`define SFP_CFG_QUAD 1
`define SFP_CFG_FREEZE 0
`define SFP_CFG_USED_MASK 8'h2F
`define SFP_CFG_RESET 8'h00

// Status register bit positions.
`define SFP_ST_WIP 0
`define SFP_ST_WEL 1
`define SFP_ST_BP_LSB 2
`define SFP_ST_BP_MSB 4
`define SFP_ST_STATUS_WRITE_DISABLE 7
`define SFP_BP_ALL 3'h7
`define SFP_BP_NONE 3'h0

// Operation kinds handed to the array engine.
`define SFP_KIND_PAGE 3'h0
`define SFP_KIND_QPAGE 3'h1
`define SFP_KIND_WIPE64 3'h2
`define SFP_KIND_WIPEALL 3'h3
`define SFP_KIND_P4 3'h4
`define SFP_KIND_P8 3'h5
`define SFP_KIND_OTP 3'h6

// Array geometry: 8 MB array, protection granule of 128 kB.
`define SFP_ADDR_W 23
`define SFP_BLK_LSB 17
`define SFP_BLK_TOTAL 7'h40

// Frame byte counts.
`define SFP_BYTES_CMD 3'h1
`define SFP_BYTES_WRR 3'h2
`define SFP_BYTES_ADDR 3'h4
`define SFP_BYTES_DATA 3'h5
`define SFP_BYTES_MAX 3'h7
`define SFP_BIT_LAST 3'h7

`endif

//--- sfp_sync.v
// Two-flop synchroniser for a group of asynchronous pin inputs.
// Assumes the inputs are quasi-static relative to sys_clk.
`include "sfp_defs.vh"
module sfp_sync #(
  parameter W = 5
) (
  // Clock and reset.
  input wire sys_clk,
  input wire nrst,
  // Raw and synchronised levels.
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);

  reg [W-1:0] stage1;

  // First stage feeds only the second stage.
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      stage1 <= {W{1'b1}};
      sync_out <= {W{1'b1}};
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

//--- sfp_range_check.v
// Registered decoder of the block-protected address range.
// Assumes the address and protect code are stable a cycle before use.
`include "sfp_defs.vh"
module sfp_range_check (
  // Clock and reset.
  input wire sys_clk,
  input wire nrst,
  // Protection setting.
  input wire [2:0] bp,
  input wire origin_bottom,
  // Target of the command.
  input wire [`SFP_ADDR_W-1:0] addr,
  input wire whole_array,
  // Result.
  output reg protected_hit
);

  // Number of 128 kB granules covered by a protect code.
  function [6:0] granules;
    input [2:0] code;
    begin
      if (code == `SFP_BP_NONE)
        granules = 7'h00;
      else if (code == `SFP_BP_ALL)
        granules = `SFP_BLK_TOTAL;
      else
        granules = 7'h01 << (code - 3'h1);
    end
  endfunction

  wire [6:0] n = granules(bp);
  wire [6:0] blk = {1'b0, addr[`SFP_ADDR_W-1:`SFP_BLK_LSB]};
  wire [6:0] top_start = `SFP_BLK_TOTAL - n;

  // Top ranges grow down from the end, bottom ranges up from zero.
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst)
      protected_hit <= 1'b1;
    else if (whole_array)
      protected_hit <= (n != 7'h00);
    else if (origin_bottom)
      protected_hit <= (blk < n);
    else
      protected_hit <= (blk >= top_start);
  end
endmodule

//--- sfp_protect_core.v
// Protection, configuration and pause logic of a serial flash.
// Assumes an external array engine that runs the issued operations,
// a non-volatile store that presents saved images at power-on, and
// a host that drives chip select, serial clock and data asynchronously.
`include "sfp_defs.vh"
module sfp_protect_core #(
  parameter [7:0] OP_WRITE_ENABLE_COMMAND = `SFP_OP_WRITE_ENABLE_COMMAND_DEF,
  parameter [7:0] OP_WRITE_DISABLE_COMMAND = `SFP_OP_WRITE_DISABLE_COMMAND_DEF,
  parameter [7:0] OP_WRR = `SFP_OP_WRR_DEF,
  parameter [7:0] OP_RDSR = `SFP_OP_RDSR_DEF,
  parameter [7:0] OP_RDCR = `SFP_OP_RDCR_DEF,
  parameter [7:0] OP_PP = `SFP_OP_PP_DEF,
  parameter [7:0] OP_QPP = `SFP_OP_QPP_DEF,
  parameter [7:0] OP_SE = `SFP_OP_SE_DEF,
  parameter [7:0] OP_BE = `SFP_OP_BE_DEF,
  parameter [7:0] OP_P4E = `SFP_OP_P4E_DEF,
  parameter [7:0] OP_P8E = `SFP_OP_P8E_DEF,
  parameter [7:0] OP_ONE_TIME_AREA_PROGRAM = `SFP_OP_ONE_TIME_AREA_PROGRAM_DEF
) (
  // Clock and power-on reset.
  input wire sys_clk,
  input wire nrst,
  // Serial pins from the host.
  input wire cs_n,
  input wire sck,
  input wire si,
  input wire hold_n,
  input wire write_protect_pin_n,
  // Serial output pin.
  output reg so,
  output reg so_oe,
  // Saved register images from the non-volatile store.
  input wire [7:0] nv_config,
  input wire [7:0] nv_status,
  // Array engine handshake.
  input wire op_busy,
  input wire op_done,
  output reg op_start,
  output reg [2:0] op_kind,
  output reg [`SFP_ADDR_W-1:0] op_addr,
  // Register state for the store and the rest of the chip.
  output reg [7:0] device_configuration,
  output reg [7:0] status_out,
  output reg write_enable_latch,
  output reg pause_active
);

  // Pause states.
  localparam [1:0] PS_RUN = 2'b00;
  localparam [1:0] PS_ENTER = 2'b01;
  localparam [1:0] PS_HELD = 2'b10;
  localparam [1:0] PS_EXIT = 2'b11;

  wire [4:0] pins_s;
  wire s_cs, s_sck, s_si, s_hold, s_wp;
  reg p_cs, p_sck, p_hold;
  reg [1:0] pstate;
  reg loaded;
  reg [2:0] bp;
  reg status_write_disable;
  reg [2:0] bit_lo;
  reg [2:0] byte_cnt;
  reg [6:0] shreg;
  reg [7:0] opcode;
  reg [23:0] addr;
  reg [7:0] wr_stat;
  reg [7:0] wr_cfg;
  reg [7:0] out_sh;
  reg out_act;
  wire prot_hit;

  // All host pins cross into the sys_clk domain first.
  sfp_sync #(.W(5)) u_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .async_in({cs_n, sck, si, hold_n, write_protect_pin_n}),
    .sync_out(pins_s)
  );
  assign {s_cs, s_sck, s_si, s_hold, s_wp} = pins_s;

  wire quad = device_configuration[`SFP_CFG_QUAD];
  wire freeze = device_configuration[`SFP_CFG_FREEZE];
  wire origin_bottom = device_configuration[`SFP_CFG_ORIGIN];
  wire sck_rise = s_sck & ~p_sck;
  wire sck_fall = ~s_sck & p_sck;
  wire hold_fall = ~s_hold & p_hold;
  wire hold_rise = s_hold & ~p_hold;
  wire cs_fall = ~s_cs & p_cs;
  wire cs_rise = s_cs & ~p_cs;
  wire paused = (pstate == PS_HELD) || (pstate == PS_EXIT);
  wire ser_rise = sck_rise & ~paused & ~s_cs;
  wire ser_fall = sck_fall & ~paused & ~s_cs;
  wire byte_done = ser_rise && (bit_lo == `SFP_BIT_LAST);
  wire [7:0] new_byte = {shreg, s_si};
  // The pin is reused as a data line in four-line mode.
  wire hw_lock = status_write_disable & ~s_wp & ~quad;
  wire whole = (bit_lo == 3'h0);
  wire is_be = (opcode == OP_BE);

  // Edge history of the synchronised pins; reset levels match the synchroniser's.
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      p_cs <= 1'b1;
      p_sck <= 1'b1;
      p_hold <= 1'b1;
    end else begin
      p_cs <= s_cs;
      p_sck <= s_sck;
      p_hold <= s_hold;
    end
  end

  // Pause tracking; four-line mode or a deselected device forces run.
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pstate <= PS_RUN;
    end else if (quad || s_cs) begin
      pstate <= PS_RUN;
    end else begin
      case (pstate)
        PS_RUN: begin
          if (hold_fall)
            pstate <= s_sck ? PS_ENTER : PS_HELD;
        end
        PS_ENTER: begin
          if (hold_rise)
            pstate <= PS_RUN;
          else if (sck_fall)
            pstate <= PS_HELD;
        end
        PS_HELD: begin
          if (hold_rise)
            pstate <= s_sck ? PS_EXIT : PS_RUN;
        end
        PS_EXIT: begin
          if (hold_fall)
            pstate <= PS_HELD;
          else if (sck_fall)
            pstate <= PS_RUN;
        end
        default: pstate <= PS_RUN;
      endcase
    end
  end

  // Pause flag for the rest of the chip; engine work goes on regardless.
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst)
      pause_active <= 1'b0;
    else
      pause_active <= paused;
  end

  // Frame capture: opcode, address and register-write payload.
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      bit_lo <= 3'h0;
      byte_cnt <= 3'h0;
      shreg <= 7'h00;
      opcode <= 8'h00;
      addr <= 24'h00_0000;
      wr_stat <= 8'h00;
      wr_cfg <= 8'h00;
    end else if (cs_fall || (cs_rise && paused)) begin
      bit_lo <= 3'h0;
      byte_cnt <= 3'h0;
      shreg <= 7'h00;
      opcode <= 8'h00;
    end else if (ser_rise) begin
      shreg <= new_byte[6:0];
      bit_lo <= bit_lo + 3'h1;
      if (byte_done) begin
        if (byte_cnt != `SFP_BYTES_MAX)
          byte_cnt <= byte_cnt + 3'h1;
        if (byte_cnt == 3'h0)
          opcode <= new_byte;
        else if (byte_cnt < `SFP_BYTES_ADDR)
          addr <= {addr[15:0], new_byte};
        if (byte_cnt == 3'h1)
          wr_stat <= new_byte;
        if (byte_cnt == 3'h2)
          wr_cfg <= new_byte;
      end
    end
  end

  // Range check of the captured target address.
  sfp_range_check u_range (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .bp(bp),
    .origin_bottom(origin_bottom),
    .addr(addr[`SFP_ADDR_W-1:0]),
    .whole_array(is_be),
    .protected_hit(prot_hit)
  );

  // Readback shifter for the status and configuration reads.
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      out_sh <= 8'h00;
      out_act <= 1'b0;
      so <= 1'b0;
      so_oe <= 1'b0;
    end else begin
      if (s_cs) begin
        out_act <= 1'b0;
      end else if (byte_done && byte_cnt == 3'h0) begin
        out_act <= (new_byte == OP_RDSR) || (new_byte == OP_RDCR);
        out_sh <= (new_byte == OP_RDCR) ? device_configuration : status_out;
      end else if (ser_fall && out_act) begin
        so <= out_sh[7];
        out_sh <= {out_sh[6:0], out_sh[7]};
      end
      so_oe <= out_act & ~s_cs & ~paused;
    end
  end

  // Which modifying command, if any, the finished frame asks for.
  reg is_op;
  reg [2:0] kind;
  reg [2:0] need;
  always @* begin
    is_op = 1'b1;
    kind = `SFP_KIND_PAGE;
    need = `SFP_BYTES_ADDR;
    case (opcode)
      OP_PP: need = `SFP_BYTES_DATA;
      OP_QPP: begin
        kind = `SFP_KIND_QPAGE;
        need = `SFP_BYTES_DATA;
      end
      OP_ONE_TIME_AREA_PROGRAM: begin
        kind = `SFP_KIND_OTP;
        need = `SFP_BYTES_DATA;
      end
      OP_SE: kind = `SFP_KIND_WIPE64;
      OP_P4E: kind = `SFP_KIND_P4;
      OP_P8E: kind = `SFP_KIND_P8;
      OP_BE: begin
        kind = `SFP_KIND_WIPEALL;
        need = `SFP_BYTES_CMD;
      end
      default: is_op = 1'b0;
    endcase
  end

  wire frame_end = cs_rise && !paused;
  wire op_len_ok = is_be ? (byte_cnt == need) : (byte_cnt >= need);
  wire otp_free = (kind == `SFP_KIND_OTP);
  // A modifying frame needs the latch, a whole byte count and an idle engine.
  wire op_go = frame_end && is_op && op_len_ok && whole && write_enable_latch
    && !op_busy && (otp_free || !prot_hit);
  wire wrr_go = frame_end && (opcode == OP_WRR) && whole && write_enable_latch
    && !op_busy && (byte_cnt >= `SFP_BYTES_WRR);
  wire wrr_cfg = (byte_cnt > `SFP_BYTES_WRR);
  wire write_enable_command_go = frame_end && (opcode == OP_WRITE_ENABLE_COMMAND) && whole
    && (byte_cnt == `SFP_BYTES_CMD);
  wire write_disable_command_go = frame_end && (opcode == OP_WRITE_DISABLE_COMMAND) && whole
    && (byte_cnt == `SFP_BYTES_CMD);

  // Hand accepted operations to the array engine.
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      op_start <= 1'b0;
      op_kind <= `SFP_KIND_PAGE;
      op_addr <= {`SFP_ADDR_W{1'b0}};
    end else begin
      op_start <= op_go;
      if (op_go) begin
        op_kind <= kind;
        op_addr <= addr[`SFP_ADDR_W-1:0];
      end
    end
  end

  // Write enable latch; a set in the same cycle as a clear wins.
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst)
      write_enable_latch <= 1'b0;
    else if (write_enable_command_go)
      write_enable_latch <= 1'b1;
    else if (write_disable_command_go || wrr_go || op_done)
      write_enable_latch <= 1'b0;
  end

  // Register images: loaded once after power-on, then written by frames.
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      loaded <= 1'b0;
      device_configuration <= `SFP_CFG_RESET;
      bp <= `SFP_BP_NONE;
      status_write_disable <= 1'b0;
    end else if (!loaded) begin
      loaded <= 1'b1;
      device_configuration <= nv_config & `SFP_CFG_USED_MASK;
      status_write_disable <= nv_status[`SFP_ST_STATUS_WRITE_DISABLE];
      if (nv_config[`SFP_CFG_VOLATILE])
        bp <= `SFP_BP_ALL;
      else
        bp <= nv_status[`SFP_ST_BP_MSB:`SFP_ST_BP_LSB];
    end else if (wrr_go) begin
      if (!hw_lock) begin
        status_write_disable <= wr_stat[`SFP_ST_STATUS_WRITE_DISABLE];
        if (!freeze)
          bp <= wr_stat[`SFP_ST_BP_MSB:`SFP_ST_BP_LSB];
      end
      if (wrr_cfg && !freeze) begin
        device_configuration[`SFP_CFG_ORIGIN] <= origin_bottom
          | wr_cfg[`SFP_CFG_ORIGIN];
        device_configuration[`SFP_CFG_VOLATILE] <=
          device_configuration[`SFP_CFG_VOLATILE] | wr_cfg[`SFP_CFG_VOLATILE];
        device_configuration[`SFP_CFG_PARAM_TOP] <=
          device_configuration[`SFP_CFG_PARAM_TOP] | wr_cfg[`SFP_CFG_PARAM_TOP];
        device_configuration[`SFP_CFG_QUAD] <= wr_cfg[`SFP_CFG_QUAD];
        device_configuration[`SFP_CFG_FREEZE] <= wr_cfg[`SFP_CFG_FREEZE];
      end
    end
  end

  // Status image as read back and saved.
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst)
      status_out <= 8'h00;
    else
      status_out <= {status_write_disable, 2'b00, bp, write_enable_latch, op_busy};
  end
endmodule

//--- sfp_protect_monitor.sv
// Concurrent checks on the ports of the flash protection core.
// Assumes the bind below attaches it to every instance of that core.
`include "sfp_defs.vh"
module sfp_protect_monitor (
  // Clock and reset.
  input wire sys_clk,
  input wire nrst,
  // Inputs of the core.
  input wire write_protect_pin_n,
  input wire op_busy,
  input wire op_done,
  // Outputs of the core.
  input wire so_oe,
  input wire op_start,
  input wire [2:0] op_kind,
  input wire [`SFP_ADDR_W-1:0] op_addr,
  input wire [7:0] device_configuration,
  input wire [7:0] status_out,
  input wire write_enable_latch,
  input wire pause_active
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking mon_cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  // Tells whether an address falls inside the range guarded by a protect code.
  function automatic logic hit(input logic [2:0] bp, input logic bot, input logic [22:0] a);
    logic [6:0] n;
    n = (bp == 3'h7) ? 7'h40 : ((bp == 3'h0) ? 7'h00 : (7'h01 << (bp - 3'h1)));
    hit = bot ? ({1'b0, a[22:17]} < n) : ({1'b0, a[22:17]} >= 7'h40 - n);
  endfunction

  // Hardware lock held: pin low, disable bit set, four-line mode off.
  sequence hw_lock_s;
    (!write_protect_pin_n && status_out[7] && !device_configuration[1]) [*5];
  endsequence
  // Freeze bit seen on three edges in a row.
  sequence frozen_s;
    device_configuration[0] [*3];
  endsequence

  cfg_unused_zero_a: assert property (device_configuration[7:6] == 2'h0 && !device_configuration[4])
    else $error("unused configuration bits not zero");
  start_needs_wel_a: assert property (op_start |-> $past(write_enable_latch) && !$past(op_busy))
    else $error("operation started without latch or while busy");
  done_clears_wel_a: assert property (op_done |=> !write_enable_latch)
    else $error("latch not cleared after completion");
  range_guard_a: assert property (op_start && op_kind != `SFP_KIND_OTP && op_kind != `SFP_KIND_WIPEALL |-> !hit(status_out[4:2], device_configuration[5], op_addr))
    else $error("operation started inside protected range");
  whole_wipe_guard_a: assert property (op_start && op_kind == `SFP_KIND_WIPEALL |-> status_out[4:2] == 3'h0)
    else $error("whole wipe started with protection set");
  pause_release_a: assert property (pause_active |-> !so_oe)
    else $error("output driven while paused");
  quad_no_pause_a: assert property (device_configuration[1] |-> !pause_active)
    else $error("pause taken in four-line mode");
  lock_bit_sticky_a: assert property ($past(device_configuration[0]) |-> device_configuration[0])
    else $error("protection lock bit cleared");
  sticky_bits_a: assert property ((~device_configuration & $past(device_configuration) & 8'h2C) == 8'h00)
    else $error("one-way configuration bit returned to zero");
  freeze_holds_bp_a: assert property (frozen_s |-> $stable(status_out[4:2]))
    else $error("protect bits changed while frozen");
  hw_lock_a: assert property (hw_lock_s |=> $stable(status_out[7:2]))
    else $error("locked status bits changed");
endmodule

bind sfp_protect_core sfp_protect_monitor mon_u (
  .sys_clk(sys_clk), .nrst(nrst), .write_protect_pin_n(write_protect_pin_n),
  .op_busy(op_busy), .op_done(op_done), .so_oe(so_oe), .op_start(op_start),
  .op_kind(op_kind), .op_addr(op_addr), .device_configuration(device_configuration),
  .status_out(status_out), .write_enable_latch(write_enable_latch),
  .pause_active(pause_active)
);

//--- sfp_host_model.sv
// Host serial controller model driving the flash pins.
// Assumes sys_clk from the bench; the link clock is built from it.
module sfp_host_model (
  // Clock.
  input wire sys_clk,
  // Pins toward the device.
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic hold_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle levels; the link clock stands low outside frames.
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
  end

  // Waits a number of system clock edges.
  task automatic wait_clk(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Sends nb bits of d MSB first, 32 ns per clock level.
  // After bit pz (0 means never) it pauses and pulses the clock as noise;
  // with ab set it drops select while paused and gives up the frame.
  // A negative pz pauses at bit -pz with the pause edges inside clock-high phases.
  task automatic frame(input logic [39:0] d, input int nb, input int pz, input bit ab);
    cs_n <= 1'b0;
    wait_clk(8);
    for (int i = nb - 1; i >= 0; i--) begin
      si <= d[i];
      wait_clk(8);
      sck <= 1'b1;
      if (nb - i == -pz) begin
        // Pause falls and rises while the clock is high, so each waits for a clock fall.
        wait_clk(4);
        hold_n <= 1'b0;
        wait_clk(4);
        sck <= 1'b0;
        wait_clk(8);
        sck <= 1'b1;
        si <= ~si;
        wait_clk(4);
        hold_n <= 1'b1;
        wait_clk(4);
      end else begin
        wait_clk(8);
      end
      sck <= 1'b0;
      if (nb - i == pz) begin
        wait_clk(8);
        hold_n <= 1'b0;
        wait_clk(8);
        sck <= 1'b1;
        si <= ~si;
        wait_clk(8);
        sck <= 1'b0;
        wait_clk(8);
        if (ab) begin
          cs_n <= 1'b1;
          wait_clk(8);
          hold_n <= 1'b1;
          wait_clk(16);
          return;
        end
        hold_n <= 1'b1;
        wait_clk(8);
      end
    end
    wait_clk(8);
    cs_n <= 1'b1;
    si <= ~si;
    wait_clk(16);
  endtask
endmodule

//--- spi_flash_protect_and_hold_tb_top.sv
// Self-checking bench for the flash protection core.
// Assumes the host model drives the serial pins; the bench plays the array engine.
module spi_flash_protect_and_hold_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic cs_n, sck, si, hold_n, so, so_oe, op_start, write_enable_latch, pause_active;
  logic write_protect_pin_n = 1'b1;
  logic [7:0] nv_config = 8'h00;
  logic [7:0] nv_status = 8'h00;
  logic op_busy = 1'b0;
  logic op_done = 1'b0;
  logic [2:0] op_kind;
  logic [22:0] op_addr;
  logic [7:0] device_configuration, status_out;
  logic [25:0] last_op = 26'h000_0000;
  logic [7:0] ops [7] = '{8'h02, 8'h32, 8'hD8, 8'hC7, 8'h20, 8'h40, 8'h42};
  int nby [7] = '{5, 5, 4, 1, 4, 4, 5};
  int failures = 0;
  int n_compared = 0;
  int n_starts = 0;
  int busy_cnt = 0;
  bit saw_pause = 1'b0;
  logic [7:0] rx_sh = 8'h00;

  always #2 sys_clk = ~sys_clk;

  sfp_protect_core dut_u (
    .sys_clk(sys_clk), .nrst(nrst), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
    .write_protect_pin_n(write_protect_pin_n), .so(so), .so_oe(so_oe),
    .nv_config(nv_config), .nv_status(nv_status), .op_busy(op_busy), .op_done(op_done),
    .op_start(op_start), .op_kind(op_kind), .op_addr(op_addr),
    .device_configuration(device_configuration), .status_out(status_out),
    .write_enable_latch(write_enable_latch), .pause_active(pause_active)
  );
  sfp_host_model host_u (.sys_clk(sys_clk), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n));

  // Host receiver: takes the data line at each link clock rise; a released line reads inverted.
  always @(posedge sck) begin
    rx_sh <= {rx_sh[6:0], so_oe ? so : ~so};
  end

  // Engine stand-in: records each accepted operation and ends it 20 cycles later.
  always @(posedge sys_clk) begin
    op_done <= (busy_cnt == 1) && (op_start !== 1'b1);
    if (op_start === 1'b1) begin
      n_starts <= n_starts + 1;
      last_op <= {op_kind, op_addr};
      op_busy <= 1'b1;
      busy_cnt <= 20;
    end else if (busy_cnt == 1) begin
      op_busy <= 1'b0;
      busy_cnt <= 0;
    end else if (busy_cnt > 1) begin
      busy_cnt <= busy_cnt - 1;
    end
    if (pause_active === 1'b1) begin
      saw_pause <= 1'b1;
    end
  end

  // Compares one result and counts it.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp_v);
    n_compared++;
    if (got !== exp_v) begin
      failures++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp_v);
    end
  endtask

  // Optional write enable, then a frame; checks how many operations started.
  task automatic wop(input logic [39:0] d, input int nb, input int pz, input bit we,
                     input int n_exp);
    int s0;
    s0 = n_starts;
    if (we) begin
      host_u.frame(40'h06, 8, 0, 1'b0);
    end
    host_u.frame(d, nb, pz, 1'b0);
    repeat (24) @(posedge sys_clk);
    chk(n_starts - s0, n_exp);
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Watchdog at 50000 cycles, nearly three times the expected run.
  initial begin
    #200000;
    failures++;
    results();
  end

  // Main sequence.
  initial begin
    int s0;
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk(device_configuration, 8'h00);
    chk(status_out, 8'h00);
    host_u.frame(40'h06, 8, 0, 1'b0);
    chk(write_enable_latch, 1'b1);
    host_u.frame(40'h04, 8, 0, 1'b0);
    chk(write_enable_latch, 1'b0);
    wop({8'hD8, 24'h7E_0000}, 32, 0, 1'b0, 0);
    $display("test latch done");
    for (int k = 0; k < 7; k++) begin
      wop({ops[k], 24'h01_2000, 8'h5A} >> (8 * (5 - nby[k])), 8 * nby[k], 0, 1'b1, 1);
      chk(last_op[25:23], k[2:0]);
      chk(write_enable_latch, 1'b0);
      if (k != 3) begin
        chk(last_op[22:0], 23'h01_2000);
      end
    end
    $display("test operation kinds done");
    wop({8'h01, 8'h04}, 16, 0, 1'b1, 0);
    chk(status_out[4:2], 3'h1);
    wop({8'hD8, 24'h7E_0000}, 32, 0, 1'b1, 0);
    wop({8'hD8, 24'h7D_0000}, 32, 0, 1'b1, 1);
    wop(40'hC7, 8, 0, 1'b1, 0);
    wop({8'h01, 8'h00, 1'b0}, 17, 0, 1'b1, 0);
    chk(status_out[4:2], 3'h1);
    wop({8'h01, 8'h84, 8'h20}, 24, 0, 1'b1, 0);
    chk(device_configuration, 8'h20);
    wop({8'hD8, 24'h01_0000}, 32, 0, 1'b1, 0);
    wop({8'hD8, 24'h02_0000}, 32, 0, 1'b1, 1);
    write_protect_pin_n <= 1'b0;
    wop({8'h01, 8'h00, 8'h20}, 24, 0, 1'b1, 0);
    chk(status_out[7:2], 6'h21);
    host_u.frame({8'h05, 8'h00}, 16, 0, 1'b0);
    chk(rx_sh, 8'h84);
    host_u.frame({8'h35, 8'h00}, 16, 0, 1'b0);
    chk(rx_sh, 8'h20);
    write_protect_pin_n <= 1'b1;
    wop({8'h01, 8'h00, 8'h00}, 24, 0, 1'b1, 0);
    chk(status_out, 8'h00);
    chk(device_configuration, 8'h20);
    $display("test protection done");
    wop({8'hD8, 24'h40_0000}, 32, 12, 1'b1, 1);
    chk(saw_pause, 1'b1);
    chk(last_op, {3'h2, 23'h40_0000});
    saw_pause = 1'b0;
    wop({8'hD8, 24'h40_0000}, 32, -20, 1'b1, 1);
    chk(saw_pause, 1'b1);
    s0 = n_starts;
    host_u.frame(40'h06, 8, 0, 1'b0);
    host_u.frame({8'hD8, 24'h40_0000}, 32, 12, 1'b1);
    repeat (24) @(posedge sys_clk);
    chk(n_starts - s0, 0);
    wop({8'h01, 8'h00, 8'h22}, 24, 0, 1'b1, 0);
    chk(device_configuration, 8'h22);
    saw_pause = 1'b0;
    wop({8'hD8, 24'h40_0000}, 32, 12, 1'b1, 0);
    chk(saw_pause, 1'b0);
    $display("test pause done");
    wop({8'h01, 8'h08, 8'h22}, 24, 0, 1'b1, 0);
    wop({8'h01, 8'h08, 8'h23}, 24, 0, 1'b1, 0);
    chk(device_configuration, 8'h23);
    wop({8'h01, 8'h00, 8'h00}, 24, 0, 1'b1, 0);
    chk(device_configuration, 8'h23);
    chk(status_out[4:2], 3'h2);
    nrst <= 1'b0;
    nv_config <= 8'h0C;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk(device_configuration, 8'h0C);
    chk(status_out[4:2], 3'h7);
    wop({8'hD8, 24'h00_0000}, 32, 0, 1'b1, 0);
    $display("test power-on reload done");
    results();
  end
endmodule
